// file: inc/tssc_pkg.sv
// Constants for the timer source and stop control block.
// Assumes a 32-bit classic Wishbone slave with byte addresses on adr_i.
package tssc_pkg;
   localparam int NUM_TIMERS = 4;
   localparam int CNT_W      = 8;
   localparam int ADR_W      = 8;
   localparam int DAT_W      = 32;
   localparam int SEL_W      = 4;
   localparam int PRESC_W    = 12;
   localparam int NUM_PINS   = 3;
   localparam int REG_STRIDE = 4;

   // Register byte offsets
   localparam logic [ADR_W-1:0] ADDR_MODE        = 8'hf4;
   localparam logic [ADR_W-1:0] ADDR_IRQ_STATUS  = 8'h00;
   localparam logic [ADR_W-1:0] ADDR_IRQ_MASK    = 8'h04;
   localparam logic [ADR_W-1:0] ADDR_RELOAD_BASE = 8'h10;

   // Mode register fields
   localparam int T1_SOURCE_SEL_A = 0;
   localparam int T2_SOURCE_SEL_A = 1;
   localparam int T1_HALT         = 2;
   localparam int T2_HALT         = 3;
   localparam int T2_SOURCE_SEL_B = 4;
   localparam int T1_SOURCE_SEL_B = 5;
   localparam int T5_CHAIN_SEL    = 6;
   localparam int T6_SOURCE_SEL   = 7;

   // Timer slots
   localparam int T1_IDX = 0;
   localparam int T2_IDX = 1;
   localparam int T5_IDX = 2;
   localparam int T6_IDX = 3;

   // Pin slots in the synchroniser
   localparam int PIN_MAIN = 0;
   localparam int PIN_SUB  = 1;
   localparam int PIN_EXT  = 2;

   // Reset values
   localparam logic [CNT_W-1:0]      MODE_RESET   = 8'h00;
   localparam logic [CNT_W-1:0]      RELOAD_RESET = 8'hff;
   localparam logic [CNT_W-1:0]      COUNT_ZERO   = 8'h00;
   localparam logic [NUM_TIMERS-1:0] IRQ_RESET    = 4'h0;
   localparam logic [PRESC_W-1:0]    PRESC_RESET  = 12'h000;

   // Prescaler taps: divide by 16 and by 4096
   localparam logic [3:0]         DIV16_TOP   = 4'hf;
   localparam logic [PRESC_W-1:0] DIV4096_TOP = 12'hfff;
   localparam logic [PRESC_W-1:0] PRESC_STEP  = 12'h001;
   localparam logic [CNT_W-1:0]   COUNT_STEP  = 8'h01;
endpackage

// file: inc/tssc_if.sv
// Link between the control logic and one 8-bit timer.
// Assumes both ends share clk_i and rst_i.
interface tssc_if;
   logic                          tick;
   logic                          halt;
   logic                          load;
   logic [tssc_pkg::CNT_W-1:0]    load_value;
   logic [tssc_pkg::CNT_W-1:0]    count;
   logic                          overflow;

   modport ctrl  (output tick, halt, load, load_value, input count, overflow);
   modport timer (input tick, halt, load, load_value, output count, overflow);
endinterface

// file: rtl/tssc_timer.sv
// One 8-bit down counter with reload and a one-cycle overflow pulse.
// Assumes tick is a one-cycle pulse on clk_i from the control logic.
module tssc_timer (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Control link
   tssc_if.timer     tif
);
   logic [tssc_pkg::CNT_W-1:0] reload;
   logic [tssc_pkg::CNT_W-1:0] count;
   logic                       overflow;
   logic [tssc_pkg::CNT_W-1:0] next_reload;
   logic [tssc_pkg::CNT_W-1:0] next_count;
   logic                       next_overflow;

   always_comb begin
      next_reload   = reload;
      next_count    = count;
      next_overflow = 1'b0;
      if (tif.load) begin
         next_reload = tif.load_value;
         next_count  = tif.load_value;
      end else if (tif.tick && !tif.halt) begin // R5
         if (count == tssc_pkg::COUNT_ZERO) begin
            next_count    = reload;
            next_overflow = 1'b1; // R9
         end else begin
            next_count = count - tssc_pkg::COUNT_STEP;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reload   <= tssc_pkg::RELOAD_RESET;
         count    <= tssc_pkg::RELOAD_RESET;
         overflow <= 1'b0;
      end else begin
         reload   <= next_reload;
         count    <= next_count;
         overflow <= next_overflow;
      end
   end

   assign tif.count    = count;
   assign tif.overflow = overflow;
endmodule

// file: rtl/tssc_top.sv
// Count source selection and start/stop for timers 1, 2, 5 and 6.
// Assumes a classic Wishbone master on clk_i; oscillator and pin inputs are
// asynchronous and far slower than clk_i.
// Behaviour
// R1 - Bit 0: timer 1 div16 or bit-5 source
// R2 - Bit 5: timer 1 div4096 or external pin
// R3 - Bit 1: timer 2 bit-4 source or pin
// R4 - Bit 4: timer 2 div16 or timer 1 overflow
// R5 - Bits 2, 3 halt timers 1, 2
// R6 - Bit 6: timer 5 from timer 2 or 4
// R7 - Bit 7: timer 6 div16 or timer 5 overflow
// R8 - Divided sources follow main or sub oscillator select
// R9 - Mode register resets zero; timers pulse overflow
//
// The implementer's own choice: the Wishbone register port.
module tssc_top (
   // Clock and reset
   input  wire logic                               clk_i,
   input  wire logic                               rst_i,
   // Wishbone slave
   input  wire logic                               cyc_i,
   input  wire logic                               stb_i,
   input  wire logic                               we_i,
   input  wire logic [tssc_pkg::ADR_W-1:0]         adr_i,
   input  wire logic [tssc_pkg::SEL_W-1:0]         sel_i,
   input  wire logic [tssc_pkg::DAT_W-1:0]         dat_i,
   output logic      [tssc_pkg::DAT_W-1:0]         dat_o,
   output logic                                    ack_o,
   // Pins
   input  wire logic                               main_osc_input_i,
   input  wire logic                               sub_osc_input_i,
   input  wire logic                               ext_count_clock_pin_i,
   // Neighbouring logic on clk_i
   input  wire logic                               osc_sub_sel_i,
   input  wire logic                               t4_overflow_i,
   input  wire logic                               t5_halt_i,
   input  wire logic                               t6_halt_i,
   // Events
   output logic      [tssc_pkg::NUM_TIMERS-1:0]    overflow_o,
   output logic                                    irq_o
);
   localparam int NT = tssc_pkg::NUM_TIMERS;
   localparam int CW = tssc_pkg::CNT_W;

   // Bus and register state
   logic [CW-1:0]                  timer_source_stop_control;
   logic [NT-1:0]                  irq_status;
   logic [NT-1:0]                  irq_mask;
   logic [tssc_pkg::DAT_W-1:0]     next_dat_o;
   logic                           next_ack_o;
   logic [CW-1:0]                  next_mode;
   logic [NT-1:0]                  next_irq_status;
   logic [NT-1:0]                  next_irq_mask;

   // Synchroniser and prescaler state
   logic [tssc_pkg::NUM_PINS-1:0]  pin_meta;
   logic [tssc_pkg::NUM_PINS-1:0]  pin_sync;
   logic                           osc_prev;
   logic                           ext_prev;
   logic [tssc_pkg::PRESC_W-1:0]   presc;
   logic [tssc_pkg::NUM_PINS-1:0]  next_pin_meta;
   logic [tssc_pkg::NUM_PINS-1:0]  next_pin_sync;
   logic                           next_osc_prev;
   logic                           next_ext_prev;
   logic [tssc_pkg::PRESC_W-1:0]   next_presc;

   // Derived strobes
   logic                           bus_req;
   logic                           bus_wr;
   logic                           osc_level;
   logic                           osc_edge;
   logic                           ext_edge;
   logic                           div16_tick;
   logic                           div4096_tick;
   logic [NT-1:0]                  tick;
   logic [NT-1:0]                  halt;
   logic [NT-1:0]                  load;
   logic [NT-1:0]                  ovf;
   logic [CW-1:0]                  count [NT];
   logic [CW-1:0]                  rd_byte;
   logic [NT-1:0]                  irq_clear;

   // Bus request; the write lands on the edge where the master sees ack
   assign bus_req = cyc_i & stb_i;
   assign bus_wr  = bus_req & we_i & ack_o & sel_i[0];

   // ---------------- Pin synchroniser and oscillator prescaler
   always_comb begin
      next_pin_meta = {ext_count_clock_pin_i, sub_osc_input_i, main_osc_input_i};
      next_pin_sync = pin_meta;
      next_osc_prev = osc_level;
      next_ext_prev = pin_sync[tssc_pkg::PIN_EXT];
      next_presc    = presc;
      if (osc_edge) begin
         next_presc = presc + tssc_pkg::PRESC_STEP;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_meta <= '0;
         pin_sync <= '0;
         osc_prev <= 1'b0;
         ext_prev <= 1'b0;
         presc    <= tssc_pkg::PRESC_RESET;
      end else begin
         pin_meta <= next_pin_meta;
         pin_sync <= next_pin_sync;
         osc_prev <= next_osc_prev;
         ext_prev <= next_ext_prev;
         presc    <= next_presc;
      end
   end

   // One prescaler serves every divided source, so all divided taps
   // share one phase; the oscillator must stay below half of clk_i.
   assign osc_level    = osc_sub_sel_i ? pin_sync[tssc_pkg::PIN_SUB]
                                       : pin_sync[tssc_pkg::PIN_MAIN]; // R8
   assign osc_edge     = osc_level & ~osc_prev;
   assign ext_edge     = pin_sync[tssc_pkg::PIN_EXT] & ~ext_prev;
   assign div16_tick   = osc_edge && (presc[3:0] == tssc_pkg::DIV16_TOP);
   assign div4096_tick = osc_edge && (presc == tssc_pkg::DIV4096_TOP);

   // ---------------- Count source selection and gating
   always_comb begin
      // Timer 1
      if (!timer_source_stop_control[tssc_pkg::T1_SOURCE_SEL_A]) begin
         tick[tssc_pkg::T1_IDX] = div16_tick; // R1
      end else if (timer_source_stop_control[tssc_pkg::T1_SOURCE_SEL_B]) begin
         tick[tssc_pkg::T1_IDX] = ext_edge; // R2
      end else begin
         tick[tssc_pkg::T1_IDX] = div4096_tick; // R2
      end
      // Timer 2
      if (timer_source_stop_control[tssc_pkg::T2_SOURCE_SEL_A]) begin
         tick[tssc_pkg::T2_IDX] = ext_edge; // R3
      end else if (timer_source_stop_control[tssc_pkg::T2_SOURCE_SEL_B]) begin
         tick[tssc_pkg::T2_IDX] = ovf[tssc_pkg::T1_IDX]; // R4
      end else begin
         tick[tssc_pkg::T2_IDX] = div16_tick; // R4
      end
      // Timer 5
      if (timer_source_stop_control[tssc_pkg::T5_CHAIN_SEL]) begin
         tick[tssc_pkg::T5_IDX] = t4_overflow_i; // R6
      end else begin
         tick[tssc_pkg::T5_IDX] = ovf[tssc_pkg::T2_IDX]; // R6
      end
      // Timer 6
      if (timer_source_stop_control[tssc_pkg::T6_SOURCE_SEL]) begin
         tick[tssc_pkg::T6_IDX] = ovf[tssc_pkg::T5_IDX]; // R7
      end else begin
         tick[tssc_pkg::T6_IDX] = div16_tick; // R7
      end
   end

   assign halt[tssc_pkg::T1_IDX] = timer_source_stop_control[tssc_pkg::T1_HALT]; // R5
   assign halt[tssc_pkg::T2_IDX] = timer_source_stop_control[tssc_pkg::T2_HALT]; // R5
   assign halt[tssc_pkg::T5_IDX] = t5_halt_i;
   assign halt[tssc_pkg::T6_IDX] = t6_halt_i;

   // ---------------- Timers
   for (genvar i = 0; i < NT; i++) begin : g_tmr
      tssc_if tif ();

      assign load[i] = bus_wr && (adr_i == tssc_pkg::ADDR_RELOAD_BASE
                                  + 8'(tssc_pkg::REG_STRIDE * i));
      assign tif.tick       = tick[i];
      assign tif.halt       = halt[i];
      assign tif.load       = load[i];
      assign tif.load_value = dat_i[CW-1:0];
      assign count[i]       = tif.count;
      assign ovf[i]         = tif.overflow;

      tssc_timer u_timer (
         .clk_i (clk_i),
         .rst_i (rst_i),
         .tif   (tif.timer)
      );
   end

   // ---------------- Register read mux
   always_comb begin
      rd_byte = '0;
      if (adr_i == tssc_pkg::ADDR_MODE) begin
         rd_byte = timer_source_stop_control;
      end else if (adr_i == tssc_pkg::ADDR_IRQ_STATUS) begin
         rd_byte[NT-1:0] = irq_status;
      end else if (adr_i == tssc_pkg::ADDR_IRQ_MASK) begin
         rd_byte[NT-1:0] = irq_mask;
      end else begin
         for (int j = 0; j < NT; j++) begin
            if (adr_i == tssc_pkg::ADDR_RELOAD_BASE + 8'(tssc_pkg::REG_STRIDE * j)) begin
               rd_byte = count[j];
            end
         end
      end
   end

   // ---------------- Bus slave and registers
   always_comb begin
      next_ack_o      = bus_req & ~ack_o;
      next_dat_o      = dat_o;
      next_mode       = timer_source_stop_control;
      next_irq_mask   = irq_mask;
      irq_clear       = '0;
      if (bus_req && !ack_o) begin
         next_dat_o = {24'h000000, rd_byte};
      end
      if (bus_wr) begin
         if (adr_i == tssc_pkg::ADDR_MODE) begin
            next_mode = dat_i[CW-1:0]; // R9
         end
         if (adr_i == tssc_pkg::ADDR_IRQ_MASK) begin
            next_irq_mask = dat_i[NT-1:0];
         end
         if (adr_i == tssc_pkg::ADDR_IRQ_STATUS) begin
            irq_clear = dat_i[NT-1:0];
         end
      end
      // A new overflow beats a clear in the same cycle
      next_irq_status = (irq_status & ~irq_clear) | ovf;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o                     <= 1'b0;
         dat_o                     <= '0;
         timer_source_stop_control <= tssc_pkg::MODE_RESET; // R9
         irq_status                <= tssc_pkg::IRQ_RESET;
         irq_mask                  <= tssc_pkg::IRQ_RESET;
      end else begin
         ack_o                     <= next_ack_o;
         dat_o                     <= next_dat_o;
         timer_source_stop_control <= next_mode;
         irq_status                <= next_irq_status;
         irq_mask                  <= next_irq_mask;
      end
   end

   assign overflow_o = ovf; // R9
   assign irq_o      = |(irq_status & irq_mask);
endmodule

// file: tb/tssc_sva.sv
// Port-level checks for the timer source and stop control block.
// Assumes it is bound into tssc_top; shadows the mode register from bus writes.
module tssc_sva (
   // Clock, reset and bus
   input wire logic                        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o,
   input wire logic [tssc_pkg::ADR_W-1:0]  adr_i,
   input wire logic [tssc_pkg::SEL_W-1:0]  sel_i,
   input wire logic [tssc_pkg::DAT_W-1:0]  dat_i,
   input wire logic [tssc_pkg::DAT_W-1:0]  dat_o,
   // Events
   input wire logic                        t4_overflow_i,
   input wire logic [tssc_pkg::NUM_TIMERS-1:0] overflow_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mode;
   logic [7:0] next_mode;
   // Write lands on the edge where ack is seen, as the master takes it
   always_comb begin
      next_mode = mode;
      if (cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_i == tssc_pkg::ADDR_MODE) begin
         next_mode = dat_i[7:0];
      end
   end
   always_ff @(posedge clk_i) begin
      mode <= rst_i ? 8'h00 : next_mode;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_mode_rd;
      cyc_i && stb_i && !we_i && ack_o && adr_i == tssc_pkg::ADDR_MODE;
   endsequence
   property p_ack_next; s_req |=> ack_o; endproperty
   property p_ack_pulse; ack_o |=> !ack_o; endproperty
   property p_mode_read; s_mode_rd |-> dat_o == {24'h000000, mode}; endproperty
   property p_t1_halt; mode[2] && $past(mode[2]) |-> !overflow_o[0]; endproperty
   property p_t2_halt; mode[3] && $past(mode[3]) |-> !overflow_o[1]; endproperty
   property p_t1_pulse; overflow_o[0] |=> !overflow_o[0]; endproperty
   property p_t2_chain;
      overflow_o[1] && $past(mode[4]) && !$past(mode[1]) |-> $past(overflow_o[0]);
   endproperty
   property p_t5_from_t2; overflow_o[2] && !$past(mode[6]) |-> $past(overflow_o[1]); endproperty
   property p_t5_from_t4; overflow_o[2] && $past(mode[6]) |-> $past(t4_overflow_i); endproperty
   property p_t6_chain; overflow_o[3] && $past(mode[7]) |-> $past(overflow_o[2]); endproperty
   a_ack_next: assert property (p_ack_next) else $error("no ack after request");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   a_mode_read: assert property (p_mode_read) else $error("mode read mismatch");
   a_t1_halt: assert property (p_t1_halt) else $error("timer 1 ran while halted");
   a_t2_halt: assert property (p_t2_halt) else $error("timer 2 ran while halted");
   a_t1_pulse: assert property (p_t1_pulse) else $error("timer 1 pulse too long");
   a_t2_chain: assert property (p_t2_chain) else $error("timer 2 not from timer 1");
   a_t5_from_t2: assert property (p_t5_from_t2) else $error("timer 5 not from 2");
   a_t5_from_t4: assert property (p_t5_from_t4) else $error("timer 5 not from 4");
   a_t6_chain: assert property (p_t6_chain) else $error("timer 6 not from 5");
endmodule

bind tssc_top tssc_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .we_i(we_i), .ack_o(ack_o), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
   .t4_overflow_i(t4_overflow_i), .overflow_o(overflow_o));

// file: tb/test_tssc_top.sv
// Self-checking bench for the timer source and stop control block.
// Assumes the bound checker; drives all pins itself at 40 MHz.
module test_tssc_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
   logic [7:0]  adr_i = 8'h00;
   logic [3:0]  sel_i = 4'hf;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic        ack_o, irq_o, main_osc = 0, sub_osc = 0, pin = 0, osc_sub_sel = 0, t4_ovf = 0;
   logic [3:0]  overflow_o;
   logic [7:0]  ovc [4] = '{default: 8'h00};
   logic [7:0]  base [4];
   int          n_mismatch = 0, checked = 0;
   always #12.5 clk_i = ~clk_i;
   tssc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .main_osc_input_i(main_osc), .sub_osc_input_i(sub_osc), .ext_count_clock_pin_i(pin),
      .osc_sub_sel_i(osc_sub_sel), .t4_overflow_i(t4_ovf), .t5_halt_i(1'b0), .t6_halt_i(1'b0),
      .overflow_o(overflow_o), .irq_o(irq_o));
   // Overflow pulses are tallied so scenarios compare deltas
   always @(posedge clk_i) begin
      for (int i = 0; i < 4; i++) ovc[i] <= ovc[i] + {7'h00, overflow_o[i]};
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Waits for ack however long it takes; only the watchdog ends a hang
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'hf;
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0; stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic pulses(input int n);
      repeat (n) begin
         pin <= 1'b1; repeat (4) @(posedge clk_i);
         pin <= 1'b0; repeat (4) @(posedge clk_i);
      end
      repeat (12) @(posedge clk_i);
   endtask
   // Each osc rising edge is four clocks apart, well under half the clock rate
   task automatic osc(input logic use_sub, input int n);
      repeat (n) begin
         if (use_sub) sub_osc <= 1'b1; else main_osc <= 1'b1;
         repeat (2) @(posedge clk_i);
         main_osc <= 1'b0; sub_osc <= 1'b0;
         repeat (2) @(posedge clk_i);
      end
      repeat (8) @(posedge clk_i);
   endtask
   task automatic delta(input int i, input logic [7:0] exp);
      cmp({24'h0, ovc[i] - base[i]}, {24'h0, exp});
   endtask
   task automatic t_regs;
      wb(0, tssc_pkg::ADDR_MODE, 0); cmp(rd, 32'h0);
      wb(1, tssc_pkg::ADDR_MODE, 32'hff); wb(0, tssc_pkg::ADDR_MODE, 0); cmp(rd, 32'hff);
      wb(0, 8'h40, 0); cmp(rd, 32'h0);
      $display("test regs done");
   endtask
   task automatic t_chain;
      wb(1, 8'h10, 0); wb(1, 8'h14, 2); wb(1, 8'h18, 0); wb(1, 8'h1c, 0);
      wb(1, tssc_pkg::ADDR_IRQ_STATUS, 32'hf);
      wb(1, tssc_pkg::ADDR_MODE, 32'hb1);
      base = ovc; pulses(3);
      delta(0, 3);
      delta(1, 1);
      delta(2, 1);
      delta(3, 1);
      wb(0, tssc_pkg::ADDR_IRQ_STATUS, 0); cmp(rd, 32'hf); cmp(irq_o, 0);
      wb(1, tssc_pkg::ADDR_IRQ_MASK, 32'h2); cmp(irq_o, 1);
      wb(1, tssc_pkg::ADDR_IRQ_STATUS, 32'h2); cmp(irq_o, 0);
      wb(0, tssc_pkg::ADDR_IRQ_STATUS, 0); cmp(rd, 32'hd);
      $display("test chain done");
   endtask
   task automatic t_pin_halt;
      wb(1, tssc_pkg::ADDR_MODE, 32'hbd); base = ovc; pulses(2);
      delta(0, 0);
      delta(1, 0);
      wb(1, 8'h14, 0); wb(1, tssc_pkg::ADDR_MODE, 32'h02); base = ovc; pulses(2);
      delta(1, 2);
      delta(0, 0);
      $display("test pin and halt done");
   endtask
   task automatic t_t4;
      wb(1, 8'h18, 0); wb(1, tssc_pkg::ADDR_MODE, 32'h40); base = ovc;
      repeat (2) begin
         t4_ovf <= 1'b1; @(posedge clk_i);
         t4_ovf <= 1'b0; repeat (4) @(posedge clk_i);
      end
      delta(2, 2);
      $display("test timer 4 chain done");
   endtask
   task automatic t_osc;
      wb(1, tssc_pkg::ADDR_MODE, 0); osc_sub_sel <= 1'b1; base = ovc; osc(1, 32);
      delta(0, 2);
      osc_sub_sel <= 1'b0; base = ovc; osc(1, 32);
      delta(0, 0);
      base = ovc; osc(0, 32);
      delta(0, 2);
      $display("test oscillator done");
   endtask
   // Any 4096 consecutive oscillator edges hold exactly one slow tap
   task automatic t_div4096;
      wb(1, tssc_pkg::ADDR_MODE, 32'h01); base = ovc; osc(0, 4096);
      delta(0, 1);
      $display("test slow divider done");
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs; t_chain; t_pin_halt; t_t4; t_osc; t_div4096;
      summarize;
   end
   initial begin
      // Slow divider test alone needs about 16.4k cycles
      #(25 * 40000);
      n_mismatch++;
      summarize;
   end
endmodule
